/* design/c16d_cond_eval.sv */
// Branch condition evaluator against the processor flags
`timescale 1ns/1ps
module c16d_cond_eval
	import c16d_pkg::*;
(
	input  wire logic [3:0] cond,
	input  wire logic       flag_n,
	input  wire logic       flag_z,
	input  wire logic       flag_c,
	input  wire logic       flag_v,
	output logic            taken
);
	// Pure combinational, registered by the decoder
	always_comb
	begin
		case (cond)
			C16D_CC_EQ: taken = flag_z;
			C16D_CC_NE: taken = !flag_z;
			C16D_CC_CS: taken = flag_c;
			C16D_CC_CC: taken = !flag_c;
			C16D_CC_MI: taken = flag_n;
			C16D_CC_PL: taken = !flag_n;
			C16D_CC_VS: taken = flag_v;
			C16D_CC_VC: taken = !flag_v;
			C16D_CC_HI: taken = flag_c && !flag_z;
			C16D_CC_LS: taken = !flag_c || flag_z;
			C16D_CC_GE: taken = flag_n == flag_v;
			C16D_CC_LT: taken = flag_n != flag_v;
			C16D_CC_GT: taken = !flag_z && (flag_n == flag_v);
			C16D_CC_LE: taken = flag_z || (flag_n != flag_v);
			C16D_CC_AL: taken = 1'b1;
			default:    taken = 1'b0;
		endcase
	end
endmodule

/* design/c16d_decoder.sv */
// Compact 16-bit instruction decoder, one halfword per valid cycle
`timescale 1ns/1ps
module c16d_decoder
	import c16d_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  srst,
	input  wire logic                  instr_valid,
	input  wire logic [C16D_HW_W-1:0]  instr,
	input  wire logic                  flag_n,
	input  wire logic                  flag_z,
	input  wire logic                  flag_c,
	input  wire logic                  flag_v,
	output logic                       dec_valid,
	output c16d_fmt_t                  dec_fmt,
	output logic [3:0]                 dec_op,
	output logic [3:0]                 dest_reg,
	output logic [3:0]                 src_reg_field,
	output logic [2:0]                 base_reg_field,
	output logic [2:0]                 offset_reg_field,
	output logic                       imm_is_operand,
	output logic [C16D_IMM_W-1:0]      dec_imm,
	output logic                       imm_negative,
	output logic                       is_load,
	output logic                       is_byte,
	output logic                       sign_extend,
	output logic [8:0]                 reg_list,
	output logic                       branch_taken,
	output logic                       link_pair_second
);
	// Whole registered state of the decoder
	typedef struct packed {
		logic                 valid;
		c16d_fmt_t            fmt;
		logic [3:0]           op;
		logic [3:0]           rd;
		logic [3:0]           src;
		logic [2:0]           base;
		logic [2:0]           ofs;
		logic                 immop;
		logic [C16D_IMM_W-1:0] imm;
		logic                 neg;
		logic                 load;
		logic                 byte_sz;
		logic                 sext;
		logic [8:0]           rlist;
		logic                 taken;
		logic                 second;
	} c16d_state_t;

	c16d_state_t state_reg;
	c16d_state_t state_next;
	logic        cond_true;

	// Zero-extend a field into the immediate width, shifted left
	function automatic logic [C16D_IMM_W-1:0] c16d_scale(
		input logic [10:0] field,
		input logic [1:0]  shift
	);
		logic [C16D_IMM_W-1:0] wide;
		wide = {1'b0, field};
		c16d_scale = wide << shift;
	endfunction

	c16d_cond_eval u_cond (
		.cond   (instr[11:8]),
		.flag_n (flag_n),
		.flag_z (flag_z),
		.flag_c (flag_c),
		.flag_v (flag_v),
		.taken  (cond_true)
	);

	// Format sort and field extraction
	always_comb
	begin
		state_next         = '0;
		state_next.fmt     = C16D_F_UNDEF;
		state_next.valid   = instr_valid;
		state_next.rd      = {1'b0, instr[2:0]};
		state_next.src     = {1'b0, instr[5:3]};
		state_next.base    = instr[5:3];
		state_next.ofs     = instr[8:6];
		case (instr[15:13])
			3'h0:
			begin
				if (instr[12:11] != 2'h3)
				begin
					state_next.fmt   = C16D_F_SHIFT;
					state_next.op    = {2'h0, instr[12:11]};
					state_next.imm   = c16d_scale({6'h00, instr[10:6]}, 2'h0);
					state_next.immop = 1'b1;
				end
				else
				begin
					state_next.fmt   = C16D_F_ADDSUB;
					state_next.immop = instr[10];
					state_next.op    = {3'h0, instr[9]};
					state_next.imm   = c16d_scale({8'h00, instr[8:6]}, 2'h0);
					state_next.ofs   = instr[8:6];
				end
			end
			3'h1:
			begin
				state_next.fmt   = C16D_F_IMM8;
				state_next.op    = {2'h0, instr[12:11]};
				state_next.rd    = {1'b0, instr[10:8]};
				state_next.imm   = c16d_scale({3'h0, instr[7:0]}, 2'h0);
				state_next.immop = 1'b1;
			end
			3'h2:
			begin
				if (instr[12:10] == 3'h0)
				begin
					state_next.fmt = C16D_F_ALU;
					state_next.op  = instr[9:6];
				end
				else if (instr[12:10] == 3'h1)
				begin
					state_next.fmt = C16D_F_HIREG;
					state_next.op  = {2'h0, instr[9:8]};
					state_next.rd  = {instr[7], instr[2:0]};
					state_next.src = {instr[6], instr[5:3]};
				end
				else if (instr[12:11] == 2'h1)
				begin
					state_next.fmt   = C16D_F_PCLOAD;
					state_next.rd    = {1'b0, instr[10:8]};
					state_next.imm   = c16d_scale({3'h0, instr[7:0]}, 2'h2);
					state_next.load  = 1'b1;
					state_next.immop = 1'b1;
				end
				else if (!instr[9])
				begin
					state_next.fmt     = C16D_F_REGOFS;
					state_next.load    = instr[11];
					state_next.byte_sz = instr[10];
				end
				else
				begin
					state_next.fmt = C16D_F_SIGNEXT;
					state_next.op  = {2'h0, instr[11:10]};
					// 00 store half, 01 signed byte, 10 half, 11 signed half
					state_next.load    = instr[11] | instr[10];
					state_next.byte_sz = !instr[11] && instr[10];
					state_next.sext    = instr[10];
				end
			end
			3'h3:
			begin
				state_next.fmt     = C16D_F_IMMOFS;
				state_next.byte_sz = instr[12];
				state_next.load    = instr[11];
				state_next.immop   = 1'b1;
				// Bytes unscaled, words scaled by four
				state_next.imm = c16d_scale({6'h00, instr[10:6]},
					instr[12] ? 2'h0 : 2'h2);
			end
			3'h4:
			begin
				state_next.load  = instr[11];
				state_next.immop = 1'b1;
				if (!instr[12])
				begin
					state_next.fmt = C16D_F_HALFOFS;
					state_next.imm = c16d_scale({6'h00, instr[10:6]}, 2'h1);
				end
				else
				begin
					state_next.fmt = C16D_F_SPREL;
					state_next.rd  = {1'b0, instr[10:8]};
					state_next.imm = c16d_scale({3'h0, instr[7:0]}, 2'h2);
				end
			end
			3'h5:
			begin
				state_next.immop = 1'b1;
				if (!instr[12])
				begin
					state_next.fmt = C16D_F_ADDR;
					state_next.op  = {3'h0, instr[11]};
					state_next.rd  = {1'b0, instr[10:8]};
					state_next.imm = c16d_scale({3'h0, instr[7:0]}, 2'h2);
				end
				else if (instr[11:8] == 4'h0)
				begin
					state_next.fmt = C16D_F_SPADJ;
					state_next.neg = instr[7];
					state_next.imm = c16d_scale({4'h0, instr[6:0]}, 2'h2);
				end
				else if (instr[10:9] == 2'h2)
				begin
					state_next.fmt   = C16D_F_PUSHPOP;
					state_next.immop = 1'b0;
					state_next.load  = instr[11];
					state_next.rlist = {instr[8], instr[7:0]};
				end
				else
				begin
					state_next.immop = 1'b0;
				end
			end
			3'h6:
			begin
				if (!instr[12])
				begin
					state_next.fmt   = C16D_F_MULTI;
					state_next.load  = instr[11];
					state_next.base  = instr[10:8];
					state_next.rlist = {1'b0, instr[7:0]};
				end
				else if (instr[11:8] == C16D_CC_TRAP)
				begin
					state_next.fmt   = C16D_F_TRAP;
					state_next.imm   = c16d_scale({3'h0, instr[7:0]}, 2'h0);
					state_next.immop = 1'b1;
				end
				else
				begin
					state_next.fmt   = C16D_F_BCOND;
					state_next.op    = instr[11:8];
					state_next.immop = 1'b1;
					// Signed halfword offset, sign carried into upper bits
					state_next.imm   = {{4{instr[7]}}, instr[7:0]};
					state_next.neg   = instr[7];
					state_next.taken = cond_true;
				end
			end
			default:
			begin
				state_next.immop = 1'b1;
				if (instr[12:11] == 2'h0)
				begin
					state_next.fmt   = C16D_F_BRANCH;
					state_next.imm   = {instr[10], instr[10:0]};
					state_next.neg   = instr[10];
					state_next.taken = 1'b1;
				end
				else if (instr[12])
				begin
					state_next.fmt    = C16D_F_LONGBL;
					state_next.second = instr[11];
					state_next.imm    = {1'b0, instr[10:0]};
				end
				else
				begin
					state_next.immop = 1'b0;
				end
			end
		endcase
		// Undefined patterns drop the load hint; register fields still pass downstream
		if (state_next.fmt == C16D_F_UNDEF)
		begin
			state_next.load = 1'b0;
		end
	end

	// One register stage, cleared by reset
	always_ff @(posedge clock)
	begin
		if (srst)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign dec_valid        = state_reg.valid;
	assign dec_fmt          = state_reg.fmt;
	assign dec_op           = state_reg.op;
	assign dest_reg         = state_reg.rd;
	assign src_reg_field    = state_reg.src;
	assign base_reg_field   = state_reg.base;
	assign offset_reg_field = state_reg.ofs;
	assign imm_is_operand   = state_reg.immop;
	assign dec_imm          = state_reg.imm;
	assign imm_negative     = state_reg.neg;
	assign is_load          = state_reg.load;
	assign is_byte          = state_reg.byte_sz;
	assign sign_extend      = state_reg.sext;
	assign reg_list         = state_reg.rlist;
	assign branch_taken     = state_reg.taken;
	assign link_pair_second = state_reg.second;
endmodule

/* shared/c16d_pkg.sv */
// Constants and types for the compact 16-bit instruction decoder
package c16d_pkg;
	localparam int C16D_HW_W    = 16;
	localparam int C16D_IMM_W   = 12;
	// Format classes presented to the execute stage
	typedef enum logic [4:0] {
		C16D_F_SHIFT   = 5'h00,
		C16D_F_ADDSUB  = 5'h01,
		C16D_F_IMM8    = 5'h02,
		C16D_F_ALU     = 5'h03,
		C16D_F_HIREG   = 5'h04,
		C16D_F_PCLOAD  = 5'h05,
		C16D_F_REGOFS  = 5'h06,
		C16D_F_SIGNEXT = 5'h07,
		C16D_F_IMMOFS  = 5'h08,
		C16D_F_HALFOFS = 5'h09,
		C16D_F_SPREL   = 5'h0A,
		C16D_F_ADDR    = 5'h0B,
		C16D_F_SPADJ   = 5'h0C,
		C16D_F_PUSHPOP = 5'h0D,
		C16D_F_MULTI   = 5'h0E,
		C16D_F_BCOND   = 5'h0F,
		C16D_F_TRAP    = 5'h10,
		C16D_F_BRANCH  = 5'h11,
		C16D_F_LONGBL  = 5'h12,
		C16D_F_UNDEF   = 5'h1F
	} c16d_fmt_t;
	// Condition codes
	localparam logic [3:0] C16D_CC_EQ = 4'h0;
	localparam logic [3:0] C16D_CC_NE = 4'h1;
	localparam logic [3:0] C16D_CC_CS = 4'h2;
	localparam logic [3:0] C16D_CC_CC = 4'h3;
	localparam logic [3:0] C16D_CC_MI = 4'h4;
	localparam logic [3:0] C16D_CC_PL = 4'h5;
	localparam logic [3:0] C16D_CC_VS = 4'h6;
	localparam logic [3:0] C16D_CC_VC = 4'h7;
	localparam logic [3:0] C16D_CC_HI = 4'h8;
	localparam logic [3:0] C16D_CC_LS = 4'h9;
	localparam logic [3:0] C16D_CC_GE = 4'hA;
	localparam logic [3:0] C16D_CC_LT = 4'hB;
	localparam logic [3:0] C16D_CC_GT = 4'hC;
	localparam logic [3:0] C16D_CC_LE = 4'hD;
	localparam logic [3:0] C16D_CC_AL = 4'hE;
	// Pattern that replaces the condition with a trap
	localparam logic [3:0] C16D_CC_TRAP = 4'hF;
endpackage

/* tb/c16d_decoder_bench.sv */
// Self-checking bench for the compact 16-bit decoder
`timescale 1ns/1ps
module c16d_decoder_bench
	import c16d_pkg::*;
;
	logic                  clock = 1'b0;
	logic                  srst = 1'b1;
	logic                  go = 1'b0;
	logic                  flag_n = 1'b0, flag_z = 1'b0;
	logic                  flag_c = 1'b0, flag_v = 1'b0;
	logic [C16D_HW_W-1:0]  hw = 16'h0000, instr;
	logic                  instr_valid, dec_valid, imm_is_operand;
	logic                  imm_negative, is_load, is_byte, sign_extend;
	logic                  branch_taken, link_pair_second;
	c16d_fmt_t             dec_fmt;
	logic [3:0]            dec_op, dest_reg, src_reg_field;
	logic [2:0]            base_reg_field, offset_reg_field;
	logic [C16D_IMM_W-1:0] dec_imm;
	logic [8:0]            reg_list;
	int                    mismatches = 0, compares = 0;
	always #2 clock = ~clock;
	c16d_fetch_model i_c16d_fetch_model (.*);
	c16d_decoder i_c16d_decoder (.*);
	task automatic conclude;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	// Called at a falling edge; result is settled one edge later
	task automatic put(logic [15:0] h, logic [3:0] f);
		go = 1'b1;
		hw = h;
		{flag_n, flag_z, flag_c, flag_v} = f;
		@(negedge clock);
	endtask
	task automatic see(c16d_fmt_t f, logic [11:0] i, logic [3:0] d);
		chk("valid", dec_valid, 1'b1);
		chk("fmt", dec_fmt, f);
		chk("imm", dec_imm, i);
		chk("dest", dest_reg, d);
	endtask
	// Branch outcome from the flags
	function automatic logic cond_ok(logic [3:0] c, logic [3:0] f);
		logic n, z, cy, v, r;
		{n, z, cy, v} = f;
		case (c[3:1])
			3'h0: r = z;
			3'h1: r = cy;
			3'h2: r = n;
			3'h3: r = v;
			3'h4: r = cy && !z;
			3'h5: r = n == v;
			3'h6: r = !z && n == v;
			default: r = 1'b1;
		endcase
		return (c == 4'hF) ? 1'b0 : r ^ (c[0] && c != 4'hE);
	endfunction
	task automatic t_arith;
		put(16'h0FFA, 4'h0);
		see(C16D_F_SHIFT, 12'h01F, 4'h2);
		chk("src", src_reg_field, 4'h7);
		chk("op", dec_op, 4'h1);
		put(16'h1C8A, 4'h0);
		see(C16D_F_ADDSUB, 12'h002, 4'h2);
		chk("immop", imm_is_operand, 1'b1);
		put(16'h1A8A, 4'h0);
		chk("immop", {imm_is_operand, dec_op}, 5'h01);
		put(16'h2BA5, 4'h0);
		see(C16D_F_IMM8, 12'h0A5, 4'h3);
		chk("op", dec_op, 4'h1);
		put(16'h43D1, 4'h0);
		see(C16D_F_ALU, 12'h000, 4'h1);
		chk("op", dec_op, 4'hF);
		put(16'h46F9, 4'h0);
		see(C16D_F_HIREG, 12'h000, 4'h9);
		chk("src", src_reg_field, 4'hF);
		$display("test arith done");
	endtask
	task automatic t_mem;
		put(16'h4DFF, 4'h0);
		see(C16D_F_PCLOAD, 12'h3FC, 4'h5);
		put(16'h5C53, 4'h0);
		see(C16D_F_REGOFS, 12'h000, 4'h3);
		chk("lbob", {is_load, is_byte, offset_reg_field,
			base_reg_field}, 8'hCA);
		for (int k = 0; k < 4; k++)
		begin
			put(16'h5200 | 16'(k << 10), 4'h0);
			chk("fmt", dec_fmt, C16D_F_SIGNEXT);
			chk("lbs", {is_load, is_byte, sign_extend},
				{k != 0, k == 1, k[0]});
		end
		put(16'h6FC8, 4'h0);
		see(C16D_F_IMMOFS, 12'h07C, 4'h0);
		put(16'h7FC8, 4'h0);
		see(C16D_F_IMMOFS, 12'h01F, 4'h0);
		chk("byte", is_byte, 1'b1);
		put(16'h8FC8, 4'h0);
		see(C16D_F_HALFOFS, 12'h03E, 4'h0);
		chk("load", is_load, 1'b1);
		put(16'h9AFF, 4'h0);
		see(C16D_F_SPREL, 12'h3FC, 4'h2);
		chk("load", is_load, 1'b1);
		put(16'hA0FF, 4'h0);
		see(C16D_F_ADDR, 12'h3FC, 4'h0);
		chk("op", dec_op, 4'h0);
		$display("test memory done");
	endtask
	task automatic t_stack;
		put(16'hB0FF, 4'h0);
		see(C16D_F_SPADJ, 12'h1FC, 4'h7);
		chk("neg", imm_negative, 1'b1);
		put(16'hBDFF, 4'h0);
		chk("fmt", dec_fmt, C16D_F_PUSHPOP);
		chk("list", {is_load, reg_list}, 10'h3FF);
		put(16'hB501, 4'h0);
		chk("list", {is_load, reg_list}, 10'h101);
		put(16'hCA81, 4'h0);
		chk("fmt", dec_fmt, C16D_F_MULTI);
		chk("list", {is_load, base_reg_field, reg_list}, 13'h1481);
		go = 1'b0;
		@(negedge clock);
		chk("valid", dec_valid, 1'b0);
		$display("test stack done");
	endtask
	task automatic t_branch;
		for (int c = 0; c < 16; c++)
			for (int f = 0; f < 16; f++)
			begin
				put({4'hD, 4'(c), 8'h80}, 4'(f));
				chk("take", branch_taken, cond_ok(4'(c), 4'(f)));
			end
		see(C16D_F_TRAP, 12'h080, 4'h0);
		put(16'hD080, 4'h0);
		see(C16D_F_BCOND, 12'hF80, 4'h0);
		put(16'hE400, 4'h0);
		see(C16D_F_BRANCH, 12'hC00, 4'h0);
		put(16'hF801, 4'h0);
		see(C16D_F_LONGBL, 12'h001, 4'h1);
		chk("second", link_pair_second, 1'b1);
		put(16'hE800, 4'h0);
		chk("fmt", dec_fmt, C16D_F_UNDEF);
		$display("test branch done");
	endtask
	initial
	begin
		repeat (10) @(negedge clock);
		srst = 1'b0;
		@(negedge clock);
		chk("valid", dec_valid, 1'b0);
		t_arith;
		t_mem;
		t_stack;
		t_branch;
		conclude;
	end
	// Cuts a hang short
	initial
	begin
		repeat (5000) @(posedge clock);
		mismatches++;
		conclude;
	end
endmodule

/* tb/c16d_fetch_model.sv */
// Fetch-side model presenting halfwords to the decoder
`timescale 1ns/1ps
module c16d_fetch_model
	import c16d_pkg::*;
(
	input  wire logic                 clock,
	input  wire logic                 go,
	input  wire logic [C16D_HW_W-1:0] hw,
	output logic                      instr_valid,
	output logic [C16D_HW_W-1:0]      instr
);
	logic [C16D_HW_W-1:0] last_reg = 16'h0000;
	// Idle bus shows the inverse, so no stale copy looks valid
	assign instr_valid = go;
	assign instr = go ? hw : ~last_reg;
	// Remember the last halfword handed over
	always @(posedge clock)
	begin
		if (go)
			last_reg <= hw;
	end
endmodule

/* tb/c16d_properties.sv */
// Decode relations checked at the decoder ports
`timescale 1ns/1ps
module c16d_props
	import c16d_pkg::*;
(
	input wire logic                 clock,
	input wire logic                 srst,
	input wire logic                 instr_valid,
	input wire logic [C16D_HW_W-1:0] instr,
	input wire logic                 flag_n,
	input wire logic                 flag_z,
	input wire logic                 flag_c,
	input wire logic                 flag_v,
	input wire logic                 dec_valid,
	input wire c16d_fmt_t            dec_fmt,
	input wire logic [3:0]           dest_reg,
	input wire logic                 imm_is_operand,
	input wire logic [11:0]          dec_imm,
	input wire logic                 imm_negative,
	input wire logic                 branch_taken
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	// Each decode lands exactly one edge after its halfword
	a_shift_imm5: assert property (instr[15:13] == 3'h0 &&
		instr[12:11] != 2'h3 |=> dec_fmt == C16D_F_SHIFT &&
		dec_imm == 12'($past(instr[10:6]))) else $error("shift field");
	a_addsub_operand: assert property (instr[15:11] == 5'h03 |=>
		imm_is_operand == $past(instr[10])) else $error("addsub kind");
	a_imm8_dest: assert property (instr[15:13] == 3'h1 |=>
		dest_reg == {1'b0, $past(instr[10:8])}) else $error("imm8 dest");
	a_hireg_banks: assert property (instr[15:10] == 6'h11 |=>
		dest_reg == {$past(instr[7]), $past(instr[2:0])})
		else $error("bank bit");
	a_pcload_scale: assert property (instr[15:11] == 5'h09 |=>
		dec_imm == {2'h0, $past(instr[7:0]), 2'h0}) else $error("pc ofs");
	a_spadj_scale: assert property (instr[15:8] == 8'hB0 |=>
		dec_imm == {3'h0, $past(instr[6:0]), 2'h0} &&
		imm_negative == $past(instr[7])) else $error("sp adjust");
	a_hi_needs_cz: assert property (instr[15:8] == 8'hD8 |=>
		branch_taken == $past(flag_c && !flag_z)) else $error("hi cond");
	a_ge_lt_flags: assert property (instr[15:9] == 7'h6D |=>
		branch_taken == ($past(flag_n == flag_v) ^ $past(instr[8])))
		else $error("ge lt cond");
	a_trap_no_branch: assert property (instr[15:8] == 8'hDF |=>
		dec_fmt == C16D_F_TRAP && !branch_taken) else $error("trap");
	a_branch_always: assert property (instr[15:11] == 5'h1C |=>
		dec_fmt == C16D_F_BRANCH && branch_taken) else $error("branch");
	cover property (instr[15:12] == 4'hD ##1 branch_taken);
	cover property (instr_valid ##1 dec_valid);
	cover property (instr[15:8] == 8'hDF ##1 dec_fmt == C16D_F_TRAP);
endmodule
bind c16d_decoder c16d_props i_c16d_props (
	.clock          (clock),
	.srst           (srst),
	.instr_valid    (instr_valid),
	.instr          (instr),
	.flag_n         (flag_n),
	.flag_z         (flag_z),
	.flag_c         (flag_c),
	.flag_v         (flag_v),
	.dec_valid      (dec_valid),
	.dec_fmt        (dec_fmt),
	.dest_reg       (dest_reg),
	.imm_is_operand (imm_is_operand),
	.dec_imm        (dec_imm),
	.imm_negative   (imm_negative),
	.branch_taken   (branch_taken)
);
